// >>> rtl/owb_map.svh
// register map, field positions, reset values and timing counts of the bit/byte writer
`ifndef OWB_MAP_SVH
`define OWB_MAP_SVH
// ==========================================================
// register byte offsets
`define OWB_CMD_OFS        12'h000
`define OWB_STATUS_OFS     12'h004
`define OWB_CONFIG_OFS     12'h008
`define OWB_RDPTR_OFS      12'h00c
`define OWB_RDDATA_OFS     12'h010
// ==========================================================
// command codes and fields
`define OWB_CODE_BIT       8'h87
`define OWB_CODE_BYTE      8'ha5
`define OWB_CMD_CODE_LSB   0
`define OWB_CMD_PARAM_LSB  8
`define OWB_BIT_V_POS      7
`define OWB_ST_BUSY        0
`define OWB_ST_SBR         1
`define OWB_ST_NAK         2
`define OWB_ST_DIR         3
`define OWB_CFG_OD         0
`define OWB_CFG_SPU        1
`define OWB_CFG_APU        2
// ==========================================================
// reset values and pointer codes
`define OWB_CFG_RST        3'h0
`define OWB_PTR_STATUS     2'h0
`define OWB_PTR_CONFIG     2'h1
// ==========================================================
// timing in ns and derived cycle counts
`define OWB_SYS_CLK_NS     100
`define OWB_LINK_CLK_NS    30
`define OWB_ACT_MAX_NS     262.5
`define OWB_ACT_MAX_CYC    ($rtoi(`OWB_ACT_MAX_NS / `OWB_SYS_CLK_NS))
`define OWB_CEIL_LNK(t)    (((t) + `OWB_LINK_CLK_NS - 1) / `OWB_LINK_CLK_NS)
`define OWB_FLOOR_LNK(t)   ((t) / `OWB_LINK_CLK_NS)
`define OWB_STD_SLOT_NS    70000
`define OWB_STD_LOW0_NS    60000
`define OWB_STD_LOW1_NS    6000
`define OWB_STD_MSR_NS     15000
`define OWB_OD_SLOT_NS     10000
`define OWB_OD_LOW0_NS     7500
`define OWB_OD_LOW1_NS     1000
`define OWB_OD_MSR_NS      2000
`define OWB_APU_NS         2000
`endif

// >>> rtl/owb_pkg.sv
// types shared by the bit/byte writer files
package owb_pkg;
	// command word handed to the link domain
	typedef struct packed {
		logic       is_byte;
		logic [7:0] data;
		logic       overdrive;
		logic       strong_pullup_enable;
		logic       active_pullup_enable;
	} cmd_word_t;
	// configuration bits
	typedef struct packed {
		logic active_pullup_enable;
		logic strong_pullup_enable;
		logic overdrive;
	} cfg_t;
	// link engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SLOT = 3'b010,
		ST_DONE = 3'b100
	} eng_state_t;
endpackage : owb_pkg

// >>> rtl/sync_stage.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sync_stage #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	// data
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;
	// next values: first stage feeds only the second
	always_comb begin
		next_meta = d_in;
		next_q    = meta;
	end
	// register both stages
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta  <= '0;
			q_out <= '0;
		end else begin
			meta  <= next_meta;
			q_out <= next_q;
		end
	end
endmodule : sync_stage

// >>> rtl/owb_writer.sv
// apb bridge with one slot engine for single-bit and write-byte commands on the link clock
`timescale 1ns/1ps
`include "owb_map.svh"
module owb_writer import owb_pkg::*; #(
	parameter int STD_SLOT = `OWB_CEIL_LNK(`OWB_STD_SLOT_NS),
	parameter int STD_LOW0 = `OWB_CEIL_LNK(`OWB_STD_LOW0_NS),
	parameter int STD_LOW1 = `OWB_CEIL_LNK(`OWB_STD_LOW1_NS),
	parameter int STD_MSR  = `OWB_FLOOR_LNK(`OWB_STD_MSR_NS),
	parameter int OD_SLOT  = `OWB_CEIL_LNK(`OWB_OD_SLOT_NS),
	parameter int OD_LOW0  = `OWB_CEIL_LNK(`OWB_OD_LOW0_NS),
	parameter int OD_LOW1  = `OWB_CEIL_LNK(`OWB_OD_LOW1_NS),
	parameter int OD_MSR   = `OWB_FLOOR_LNK(`OWB_OD_MSR_NS),
	parameter int APU_CYC  = `OWB_CEIL_LNK(`OWB_APU_NS)
) (
	// clocks and reset
	input  wire logic        sys_clk_in,
	input  wire logic        link_clk_in,
	input  wire logic        rstn_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// single-wire line, open drain
	input  wire logic        line_in,
	output logic             line_out,
	output logic             line_oe_out,
	// pullup controls
	output logic             strong_pullup_out,
	output logic             active_pullup_out
);
	// ==========================================================
	// system domain state
	cfg_t        cfg, next_cfg;
	cmd_word_t   cmd, next_cmd;
	logic        line_busy_flag, next_busy;
	logic        single_bit_result, next_sbr;
	logic        nak, next_nak;
	logic        dir_flag;
	logic [1:0]  rd_ptr, next_ptr;
	logic        start_tgl, next_start_tgl;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr;
	logic        done_s, done_d, next_done_d;
	logic        sbr_s;
	logic        apb_done, apb_wr, cmd_hit, cmd_known, accept;
	logic [7:0]  wr_code, wr_param;

	// register address decode, shared by read and write paths
	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a == `OWB_CMD_OFS) || (a == `OWB_STATUS_OFS) ||
			(a == `OWB_CONFIG_OFS) || (a == `OWB_RDPTR_OFS) || (a == `OWB_RDDATA_OFS);
	endfunction : addr_ok

	// status word layout
	function automatic logic [31:0] status_word(input logic b, input logic s,
		input logic n, input logic d);
		status_word = 32'h0000_0000;
		status_word[`OWB_ST_BUSY] = b;
		status_word[`OWB_ST_SBR]  = s;
		status_word[`OWB_ST_NAK]  = n;
		status_word[`OWB_ST_DIR]  = d;
	endfunction : status_word

	// direction flag is never moved by these commands
	assign dir_flag = 1'b0;
	// open drain: only ever pulls low
	assign line_out = 1'b0;

	// ==========================================================
	// crossings from the link domain
	logic done_tgl, sbr_link;
	sync_stage #(.W(2)) u_back_sync (
		.clk_in  (sys_clk_in),
		.rstn_in (rstn_in),
		.d_in    ({done_tgl, sbr_link}),
		.q_out   ({done_s, sbr_s})
	);

	// transfer decode
	always_comb begin
		apb_done  = psel_in && penable_in && pready_out;
		apb_wr    = apb_done && pwrite_in;
		cmd_hit   = apb_wr && (paddr_in == `OWB_CMD_OFS);
		wr_code   = pwdata_in[`OWB_CMD_CODE_LSB +: 8];
		wr_param  = pwdata_in[`OWB_CMD_PARAM_LSB +: 8];
		cmd_known = (wr_code == `OWB_CODE_BIT) || (wr_code == `OWB_CODE_BYTE);
		accept    = cmd_hit && cmd_known && !line_busy_flag;
	end

	// next values of the system domain
	always_comb begin
		next_cfg       = cfg;
		next_cmd       = cmd;
		next_busy      = line_busy_flag;
		next_sbr       = single_bit_result;
		next_nak       = nak;
		next_ptr       = rd_ptr;
		next_start_tgl = start_tgl;
		next_done_d    = done_s;
		next_pready    = psel_in && penable_in && !pready_out;
		next_pslverr   = psel_in && penable_in && !pready_out && !addr_ok(paddr_in);
		next_prdata    = 32'h0000_0000;
		// read data, answered with one wait state
		if (psel_in && penable_in && !pready_out && !pwrite_in) begin
			case (paddr_in)
				`OWB_STATUS_OFS: next_prdata = status_word(line_busy_flag,
					single_bit_result, nak, dir_flag);
				`OWB_CONFIG_OFS: next_prdata = {29'h0, cfg};
				`OWB_RDPTR_OFS:  next_prdata = {30'h0, rd_ptr};
				`OWB_RDDATA_OFS: next_prdata = (rd_ptr == `OWB_PTR_CONFIG) ? {29'h0, cfg} :
					status_word(line_busy_flag, single_bit_result, nak, dir_flag);
				default:         next_prdata = 32'h0000_0000;
			endcase
		end
		// completion from link engine
		if (done_s != done_d) begin
			next_busy = 1'b0;
			if (!cmd.is_byte) begin
				next_sbr = sbr_s;
			end
		end
		// command issue or refusal
		if (cmd_hit) begin
			if (accept) begin
				next_busy         = 1'b1;
				next_nak          = 1'b0;
				next_ptr          = `OWB_PTR_STATUS;
				next_start_tgl    = !start_tgl;
				next_cmd.is_byte  = (wr_code == `OWB_CODE_BYTE);
				next_cmd.overdrive = cfg.overdrive;
				next_cmd.strong_pullup_enable      = cfg.strong_pullup_enable;
				next_cmd.active_pullup_enable      = cfg.active_pullup_enable;
				if (wr_code == `OWB_CODE_BYTE) begin
					next_cmd.data = wr_param;
				end else begin
					next_cmd.data = {7'h00, wr_param[`OWB_BIT_V_POS]};
				end
			end else begin
				next_nak = 1'b1;
			end
		end
		// configuration and pointer writes
		if (apb_wr && paddr_in == `OWB_CONFIG_OFS) begin
			next_cfg = pwdata_in[2:0];
		end
		if (apb_wr && paddr_in == `OWB_RDPTR_OFS && pwdata_in[1] == 1'b0) begin
			next_ptr = pwdata_in[1:0];
		end
	end

	// register the system domain
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg               <= `OWB_CFG_RST;
			cmd               <= '0;
			line_busy_flag    <= 1'b0;
			single_bit_result <= 1'b0;
			nak               <= 1'b0;
			rd_ptr            <= `OWB_PTR_STATUS;
			start_tgl         <= 1'b0;
			done_d            <= 1'b0;
			prdata_out        <= 32'h0000_0000;
			pready_out        <= 1'b0;
			pslverr_out       <= 1'b0;
		end else begin
			cfg               <= next_cfg;
			cmd               <= next_cmd;
			line_busy_flag    <= next_busy;
			single_bit_result <= next_sbr;
			nak               <= next_nak;
			rd_ptr            <= next_ptr;
			start_tgl         <= next_start_tgl;
			done_d            <= next_done_d;
			prdata_out        <= next_prdata;
			pready_out        <= next_pready;
			pslverr_out       <= next_pslverr;
		end
	end

	// ==========================================================
	// link domain: reset release, start toggle and line sampling
	logic lrstn;
	logic start_s, start_d, line_s;
	sync_stage #(.W(1)) u_lrst_sync (
		.clk_in  (link_clk_in),
		.rstn_in (rstn_in),
		.d_in    (1'b1),
		.q_out   (lrstn)
	);
	sync_stage #(.W(2)) u_fwd_sync (
		.clk_in  (link_clk_in),
		.rstn_in (lrstn),
		.d_in    ({start_tgl, line_in}),
		.q_out   ({start_s, line_s})
	);

	eng_state_t state, next_state;
	cmd_word_t  lcmd, next_lcmd;
	logic [11:0] cnt, next_cnt;
	logic [7:0]  shreg, next_shreg;
	logic [3:0]  bits_left, next_bits;
	logic [11:0] apu_cnt, next_apu_cnt;
	logic        next_start_d, next_done_tgl, next_sbr_link;
	logic        next_oe, next_spu_o, next_apu_o;
	logic [11:0] t_slot, t_low, t_msr;

	// slot timing by speed and bit value
	always_comb begin
		t_slot = lcmd.overdrive ? 12'(OD_SLOT) : 12'(STD_SLOT);
		t_msr  = lcmd.overdrive ? 12'(OD_MSR)  : 12'(STD_MSR);
		if (shreg[0]) begin
			t_low = lcmd.overdrive ? 12'(OD_LOW1) : 12'(STD_LOW1);
		end else begin
			t_low = lcmd.overdrive ? 12'(OD_LOW0) : 12'(STD_LOW0);
		end
	end

	// slot engine next values
	always_comb begin
		next_state    = state;
		next_lcmd     = lcmd;
		next_cnt      = cnt;
		next_shreg    = shreg;
		next_bits     = bits_left;
		next_start_d  = start_s;
		next_done_tgl = done_tgl;
		next_sbr_link = sbr_link;
		next_oe       = line_oe_out;
		next_spu_o    = strong_pullup_out;
		next_apu_o    = 1'b0;
		next_apu_cnt  = (apu_cnt != 12'h000) ? apu_cnt - 12'h001 : 12'h000;
		case (state)
			ST_IDLE: begin
				if (start_s != start_d) begin
					next_lcmd  = cmd; // stable since the toggle moved
					next_shreg = cmd.data;
					next_bits  = cmd.is_byte ? 4'h8 : 4'h1;
					next_cnt   = 12'h000;
					next_oe    = 1'b1;
					next_spu_o = 1'b0;
					next_state = ST_SLOT;
				end
			end
			ST_SLOT: begin
				next_cnt = cnt + 12'h001;
				next_oe  = (cnt + 12'h001) < t_low;
				if (cnt == t_msr) begin
					next_sbr_link = line_s;
				end
				if (cnt == t_slot - 12'h001) begin
					next_shreg = {1'b0, shreg[7:1]};
					next_bits  = bits_left - 4'h1;
					next_cnt   = 12'h000;
					if (bits_left == 4'h1) begin
						next_oe    = 1'b0;
						next_state = ST_DONE;
					end else begin
						next_oe = 1'b1;
					end
				end
			end
			ST_DONE: begin
				next_done_tgl = !done_tgl;
				next_spu_o    = lcmd.strong_pullup_enable;
				next_state    = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// active pullup window after each release
		if (line_oe_out && !next_oe && lcmd.active_pullup_enable) begin
			next_apu_cnt = 12'(APU_CYC);
		end
		if (next_apu_cnt != 12'h000) begin
			next_apu_o = 1'b1;
		end
	end

	// register the link domain
	always_ff @(posedge link_clk_in or negedge lrstn) begin
		if (!lrstn) begin
			state             <= ST_IDLE;
			lcmd              <= '0;
			cnt               <= 12'h000;
			shreg             <= 8'h00;
			bits_left         <= 4'h0;
			apu_cnt           <= 12'h000;
			start_d           <= 1'b0;
			done_tgl          <= 1'b0;
			sbr_link          <= 1'b0;
			line_oe_out       <= 1'b0;
			strong_pullup_out <= 1'b0;
			active_pullup_out <= 1'b0;
		end else begin
			state             <= next_state;
			lcmd              <= next_lcmd;
			cnt               <= next_cnt;
			shreg             <= next_shreg;
			bits_left         <= next_bits;
			apu_cnt           <= next_apu_cnt;
			start_d           <= next_start_d;
			done_tgl          <= next_done_tgl;
			sbr_link          <= next_sbr_link;
			line_oe_out       <= next_oe;
			strong_pullup_out <= next_spu_o;
			active_pullup_out <= next_apu_o;
		end
	end

	// ==========================================================
	// assertions
	AST_REFUSE_BUSY: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(cmd_hit && cmd_known && line_busy_flag) |=> (nak && start_tgl == $past(start_tgl)))
		else $error("busy command was not refused");
	AST_ACCEPT: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		accept |=> (line_busy_flag && rd_ptr == `OWB_PTR_STATUS && !nak))
		else $error("accepted command did not set busy and pointer");
	AST_BIT7_ONLY: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(accept && wr_code == `OWB_CODE_BIT) |=>
		(cmd.data == {7'h00, $past(pwdata_in[`OWB_CMD_PARAM_LSB + `OWB_BIT_V_POS])}))
		else $error("single bit value not from bit 7");
	AST_SBR_ON_DONE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$changed(single_bit_result) |-> $past(done_s != done_d))
		else $error("result changed without completion");
	AST_BUSY_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(line_busy_flag) |=> line_busy_flag [*8])
		else $error("busy dropped early");
	AST_START_FAST: assert property (@(posedge link_clk_in) disable iff (!lrstn)
		(state == ST_IDLE && start_s != start_d) |=> (line_oe_out && state == ST_SLOT))
		else $error("line activity did not start");
	AST_LSB_FIRST: assert property (@(posedge link_clk_in) disable iff (!lrstn)
		(state == ST_SLOT && cnt == t_slot - 12'h001 && bits_left != 4'h1) |=>
		(shreg == {1'b0, $past(shreg[7:1])} && line_oe_out))
		else $error("byte not shifted lsb first");
	AST_LOW_LEN: assert property (@(posedge link_clk_in) disable iff (!lrstn)
		(state == ST_SLOT && cnt != 12'h000) |-> (line_oe_out == (cnt < t_low)))
		else $error("slot low time wrong");
	AST_SAMPLE: assert property (@(posedge link_clk_in) disable iff (!lrstn)
		(state == ST_SLOT && cnt == t_msr) |=> (sbr_link == $past(line_s)))
		else $error("line not sampled at read time");
	AST_SLOT_BOUND: assert property (@(posedge link_clk_in) disable iff (!lrstn)
		(state == ST_SLOT) |-> (cnt < t_slot && bits_left != 4'h0 && bits_left <= 4'h8))
		else $error("slot counter out of range");
	COV_BIT: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
		accept && wr_code == `OWB_CODE_BIT);
	COV_BYTE: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
		accept && wr_code == `OWB_CODE_BYTE);
	COV_REFUSE: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
		cmd_hit && cmd_known && line_busy_flag);
	COV_DONE: cover property (@(posedge link_clk_in) disable iff (!lrstn)
		state == ST_DONE);
endmodule : owb_writer

// >>> testbench/line_slave.sv
// single-wire slave model: decodes slots by low time, answers read slots
`timescale 1ns/1ps
module line_slave #(
	parameter int THR_STD = 17,
	parameter int THR_OD  = 9,
	parameter int PULL    = 12
) (
	// clock and reset
	input  wire logic       link_clk_in,
	input  wire logic       rstn_in,
	// line and controls
	input  wire logic       line_in,
	input  wire logic       od_in,
	input  wire logic       answer_zero_in,
	output logic            pull_out,
	// observed slots
	output logic [7:0]      bits_out,
	output logic [7:0]      count_out
);
	logic prev;
	int   low_len;
	int   pull_len;
	// ==========================================================
	// slot decoding; short low is a one, long low is a zero
	always @(posedge link_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prev      <= 1'b1;
			low_len   <= 0;
			pull_len  <= 0;
			pull_out  <= 1'b0;
			bits_out  <= 8'h00;
			count_out <= 8'h00;
		end else begin
			prev <= line_in;
			if (!line_in) low_len <= low_len + 1;
			// hold the line low past the sample point to answer zero
			if (prev && !line_in && answer_zero_in) begin
				pull_out <= 1'b1;
				pull_len <= 0;
			end else if (pull_out) begin
				pull_len <= pull_len + 1;
				if (pull_len >= PULL - 1) pull_out <= 1'b0;
			end
			// end of low phase closes one slot, newest bit enters at the top
			if (!prev && line_in) begin
				bits_out  <= {(low_len < (od_in ? THR_OD : THR_STD)), bits_out[7:1]};
				count_out <= count_out + 8'h01;
				low_len   <= 0;
			end
		end
	end
endmodule : line_slave

// >>> testbench/tb_single_wire_bit_and_byte_writer.sv
// testbench of the bit/byte writer: apb tasks, slave model, checks
`timescale 1ns/1ps
`include "owb_map.svh"
module tb_single_wire_bit_and_byte_writer;
	localparam int SS = 40;
	localparam int OS = 24;
	localparam int SL0 = 30;
	localparam int SL1 = 4;
	localparam int SMSR = 10;
	localparam int OL0 = 16;
	localparam int OL1 = 2;
	localparam int OMSR = 6;
	localparam int ACTIVE_PULLUP_ENABLE = 2;
	logic        sys_clk_in = 0;
	logic        link_clk_in = 0;
	logic        rstn_in = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        line_out;
	logic        line_oe_out;
	logic        spu_out;
	logic        apu_out;
	logic        pull;
	logic        od = 0;
	logic        answer = 0;
	logic [7:0]  bits;
	logic [7:0]  count;
	logic [31:0] rdata;
	logic        rerr;
	wire         line_w = (line_oe_out ? line_out : 1'b1) & ~pull;
	int          mismatches = 0;
	int          n_checks = 0;
	int          apu_hi = 0;
	// ==========================================================
	// clocks, link clock unrelated in phase
	always #50 sys_clk_in = ~sys_clk_in;
	initial begin
		#7;
		forever #15 link_clk_in = ~link_clk_in;
	end
	// active pullup high cycles seen on the link clock
	always @(posedge link_clk_in) begin
		if (rstn_in && apu_out === 1'b1) apu_hi <= apu_hi + 1;
	end
	// ==========================================================
	// design and slave
	owb_writer #(.STD_SLOT(SS), .STD_LOW0(SL0), .STD_LOW1(SL1), .STD_MSR(SMSR),
		.OD_SLOT(OS), .OD_LOW0(OL0), .OD_LOW1(OL1), .OD_MSR(OMSR), .APU_CYC(ACTIVE_PULLUP_ENABLE)) i_dut (
		.sys_clk_in(sys_clk_in), .link_clk_in(link_clk_in), .rstn_in(rstn_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .line_in(line_w), .line_out(line_out),
		.line_oe_out(line_oe_out), .strong_pullup_out(spu_out), .active_pullup_out(apu_out));
	line_slave i_slave (.link_clk_in(link_clk_in), .rstn_in(rstn_in), .line_in(line_w),
		.od_in(od), .answer_zero_in(answer), .pull_out(pull), .bits_out(bits),
		.count_out(count));
	// ==========================================================
	// tasks
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 32);
		rdata = prdata_out;
		rerr = pslverr_out;
		if (n >= 32) check("pready", 1, 0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// polls busy and returns elapsed ns since t0
	task wait_idle(input realtime t0, output int ns);
		int n;
		n = 0;
		do begin
			apb(0, `OWB_STATUS_OFS, 0);
			n++;
		end while (rdata[`OWB_ST_BUSY] !== 1'b0 && n < 400);
		check("busy clears", 0, rdata[`OWB_ST_BUSY]);
		ns = int'($realtime - t0);
	endtask : wait_idle
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// ==========================================================
	// watchdog
	initial begin
		#3000000;
		mismatches++;
		finish_test();
	end
	// ==========================================================
	// tests
	initial begin
		logic [7:0] p [3];
		logic       a [3];
		logic [7:0] c0;
		logic [7:0] d;
		realtime    t0;
		int         ns;
		int         seen;
		p = '{8'h7f, 8'h80, 8'hff};
		a = '{1'b0, 1'b0, 1'b1};
		repeat (16) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		apb(0, `OWB_CONFIG_OFS, 0);
		check("config reset", 32'h0, rdata);
		apb(0, 12'h040, 0);
		check("unmapped error", 1, rerr);
		$display("test reset done");
		// single-bit slots, bit 7 alone decides
		for (int i = 0; i < 3; i++) begin
			c0 = count;
			answer <= a[i];
			apb(1, `OWB_RDPTR_OFS, 1);
			apb(1, `OWB_CMD_OFS, {16'h0, p[i], `OWB_CODE_BIT});
			t0 = $realtime;
			apb(0, `OWB_RDDATA_OFS, 0);
			check("pointer shows busy", 1, rdata[`OWB_ST_BUSY]);
			wait_idle(t0, ns);
			check("busy held one slot", 1, ns >= SS * 30);
			check("slot count", c0 + 8'h01, count);
			check("slot kind", p[i][7], bits[7]);
			check("sampled bit", p[i][7] & ~a[i], rdata[`OWB_ST_SBR]);
		end
		answer <= 1'b0;
		$display("test single bit done");
		// write-byte at both speeds
		for (int j = 0; j < 2; j++) begin
			od <= j[0];
			d = j ? 8'h2c : 8'hd3;
			c0 = count;
			apb(1, `OWB_RDPTR_OFS, 1);
			apb(1, `OWB_CONFIG_OFS, {31'h0, j[0]});
			apb(1, `OWB_CMD_OFS, {16'h0, d, `OWB_CODE_BYTE});
			t0 = $realtime;
			seen = 0;
			for (int k = 0; k < 3; k++) begin
				@(posedge sys_clk_in);
				if (line_w === 1'b0) seen = 1;
			end
			check("line activity start", 1, seen);
			wait_idle(t0, ns);
			check("eight slots", c0 + 8'h08, count);
			check("byte on line", d, bits);
			check("busy held eight slots", 1, ns >= 8 * (j ? OS : SS) * 30);
			apb(0, `OWB_RDDATA_OFS, 0);
			check("pointer on status", 0, rdata[`OWB_ST_BUSY]);
		end
		od <= 1'b0;
		$display("test write byte done");
		// commands while busy are refused
		apb(1, `OWB_CONFIG_OFS, 0);
		c0 = count;
		apb(1, `OWB_CMD_OFS, {16'h0, 8'hff, `OWB_CODE_BYTE});
		t0 = $realtime;
		apb(1, `OWB_CMD_OFS, {16'h0, 8'h80, `OWB_CODE_BIT});
		apb(0, `OWB_STATUS_OFS, 0);
		check("bit refused", 1, rdata[`OWB_ST_NAK]);
		apb(1, `OWB_CMD_OFS, {16'h0, 8'h00, `OWB_CODE_BYTE});
		apb(0, `OWB_STATUS_OFS, 0);
		check("byte refused", 1, rdata[`OWB_ST_NAK]);
		wait_idle(t0, ns);
		check("no extra slots", c0 + 8'h08, count);
		check("first byte kept", 8'hff, bits);
		// a code other than the two commands starts nothing
		apb(1, `OWB_CMD_OFS, {16'h0, 8'h80, 8'h3c});
		apb(0, `OWB_STATUS_OFS, 0);
		check("other code ignored", 32'h4, rdata & 32'h5);
		$display("test refusal done");
		// strong pullup taken from configuration
		apb(1, `OWB_CONFIG_OFS, 32'h6);
		apb(1, `OWB_CMD_OFS, {16'h0, 8'h80, `OWB_CODE_BIT});
		t0 = $realtime;
		wait_idle(t0, ns);
		check("nak cleared", 0, rdata[`OWB_ST_NAK]);
		check("strong pullup", 1, spu_out);
		check("active pullup cycles", ACTIVE_PULLUP_ENABLE, apu_hi);
		$display("test pullup done");
		finish_test();
	end
endmodule : tb_single_wire_bit_and_byte_writer
